//--- src/tofm_pkg.sv
// Shared constants and types for the torque-off fault monitor
package tofm_pkg;

  // Function-select codes
  localparam logic [3:0] FUNC_NONE = 4'h0;
  localparam logic [3:0] FUNC_TORQUE_ALARM = 4'h1;
  localparam logic [3:0] FUNC_TORQUE_ALARM_ALT = 4'h2;
  localparam logic [3:0] FUNC_TORQUE_WARN = 4'h3;
  localparam logic [3:0] FUNC_SENSOR_ONLY_TRIP = 4'h4;
  localparam logic [3:0] FUNC_SENSOR_ONLY_RESTART = 4'h5;
  localparam logic [3:0] FUNC_SENSOR_RELAY_TRIP = 4'h6;
  localparam logic [3:0] FUNC_SENSOR_RELAY_RESTART = 4'h7;
  localparam logic [3:0] FUNC_SENSOR_TRIP_RELAY_RESTART = 4'h8;
  localparam logic [3:0] FUNC_SENSOR_RESTART_RELAY_TRIP = 4'h9;

  // Status word bit positions
  localparam int BIT_TORQUE_OFF = 30;
  localparam int BIT_DANGEROUS = 31;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic torque_off_alarm;
    logic sensor_torque_off_alarm;
    logic dangerous_failure_lock;
  } tofm_alarm_type;

endpackage : tofm_pkg

//--- src/tofm_sync_if.sv
// Synchronised input pair passed from the synchroniser to the monitor
`timescale 1ns/1ps
interface tofm_sync_if;
  logic torque_disable;
  logic card_logic_output;
  modport producer (output torque_disable, output card_logic_output);
  modport consumer (input torque_disable, input card_logic_output);
endinterface : tofm_sync_if

//--- src/tofm_sync.sv
// Two-flop synchroniser for the torque-off and card logic inputs
`timescale 1ns/1ps
module tofm_sync
  import tofm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic torque_disable_n_in,
  input wire logic card_logic_output_in,
  tofm_sync_if.producer sync_out
);

  logic [1:0] raw;
  logic [1:0] stage_q [SYNC_STAGES];

  // Active-low torque-off pin turned to an active-high request
  assign raw = {~torque_disable_n_in, card_logic_output_in};

  genvar i;
  generate
    for (i = 0; i < SYNC_STAGES; i++) begin : g_stage
      // First stage samples the pins; later stages only read the stage before
      if (i == 0) begin : g_first
        always_ff @(posedge clock_in or posedge rst_in) begin
          if (rst_in) begin
            stage_q[i] <= 2'h0;
          end else begin
            stage_q[i] <= raw;
          end
        end
      end else begin : g_next
        always_ff @(posedge clock_in or posedge rst_in) begin
          if (rst_in) begin
            stage_q[i] <= 2'h0;
          end else begin
            stage_q[i] <= stage_q[i-1];
          end
        end
      end
    end
  endgenerate

  assign sync_out.torque_disable = stage_q[SYNC_STAGES-1][1];
  assign sync_out.card_logic_output = stage_q[SYNC_STAGES-1][0];

endmodule : tofm_sync

//--- src/tofm_monitor.sv
// Torque-off fault monitor: alarms, warnings, status words and run permission
`timescale 1ns/1ps
module tofm_monitor
  import tofm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic torque_disable_n_in,
  input wire logic card_logic_output_in,
  input wire logic [3:0] function_select_in,
  input wire logic reset_command_in,
  input wire logic auto_reset_in,
  output logic run_enable_out,
  output logic [31:0] trip_status_word_out,
  output logic [31:0] trip_status_word_ext_out,
  output logic [31:0] caution_status_word_out,
  output logic [31:0] caution_status_word_ext_out
);

  tofm_sync_if sync_bus ();

  tofm_sync u_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .torque_disable_n_in(torque_disable_n_in),
    .card_logic_output_in(card_logic_output_in),
    .sync_out(sync_bus.producer)
  );

  logic tdis;
  logic card;
  logic sensor_mode;
  logic sensor_only;
  logic plain_alarm;
  logic plain_warn;
  logic relay_is_alarm;
  logic sensor_is_alarm;
  logic card_stop;
  logic relay_stop;
  logic unexpected;
  logic both_clear;
  logic manual_reset;
  tofm_alarm_type alarm_q;
  logic torque_warn_d;
  logic sensor_warn_d;
  logic torque_warn_q;
  logic sensor_warn_q;
  logic run_enable_d;
  logic [31:0] trip_word_d;
  logic [31:0] trip_ext_word_d;
  logic [31:0] caution_word_d;
  logic [31:0] caution_ext_word_d;

  assign tdis = sync_bus.torque_disable;
  assign card = sync_bus.card_logic_output;

  // Setting decode
  always_comb begin
    sensor_mode = 1'b0;
    sensor_only = 1'b0;
    plain_alarm = 1'b0;
    plain_warn = 1'b0;
    relay_is_alarm = 1'b0;
    sensor_is_alarm = 1'b0;
    case (function_select_in)
      FUNC_TORQUE_ALARM, FUNC_TORQUE_ALARM_ALT: begin
        plain_alarm = 1'b1;
      end
      FUNC_TORQUE_WARN: begin
        plain_warn = 1'b1;
      end
      FUNC_SENSOR_ONLY_TRIP: begin
        sensor_mode = 1'b1;
        sensor_only = 1'b1;
        sensor_is_alarm = 1'b1;
      end
      FUNC_SENSOR_ONLY_RESTART: begin
        sensor_mode = 1'b1;
        sensor_only = 1'b1;
      end
      FUNC_SENSOR_RELAY_TRIP: begin
        sensor_mode = 1'b1;
        sensor_is_alarm = 1'b1;
        relay_is_alarm = 1'b1;
      end
      FUNC_SENSOR_RELAY_RESTART: begin
        sensor_mode = 1'b1;
      end
      // opposite severities in the mixed settings
      FUNC_SENSOR_TRIP_RELAY_RESTART: begin
        sensor_mode = 1'b1;
        sensor_is_alarm = 1'b1;
      end
      FUNC_SENSOR_RESTART_RELAY_TRIP: begin
        sensor_mode = 1'b1;
        relay_is_alarm = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // card input only matters in sensor settings
  assign card_stop = sensor_mode && tdis && card;
  assign relay_stop = tdis && !(sensor_mode && card) && !sensor_only;

  // torque-off without card in sensor-only settings
  // relay stop alone is legitimate in combined settings
  assign unexpected = sensor_mode && ((card && !tdis) || (sensor_only && tdis && !card));

  // Both lines idle: the only state in which card-related alarms may clear
  assign both_clear = !tdis && !card;
  // auto reset never clears these alarms
  // Limitation: the reset command is taken as already debounced and synchronous
  assign manual_reset = reset_command_in;

  // sticky alarms, set wins over reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_q <= '0;
    end else begin
      // clear only once torque-off input released
      if (relay_stop && (plain_alarm || relay_is_alarm)) begin
        alarm_q.torque_off_alarm <= 1'b1;
      end else if (manual_reset && !tdis) begin
        alarm_q.torque_off_alarm <= 1'b0;
      end
      // sensor alarm needs both inputs inactive then reset
      if (card_stop && sensor_is_alarm) begin
        alarm_q.sensor_torque_off_alarm <= 1'b1;
      end else if (manual_reset && both_clear) begin
        alarm_q.sensor_torque_off_alarm <= 1'b0;
      end
      // Lock also waits for a clean input pair so it cannot bounce straight back
      if (unexpected) begin
        alarm_q.dangerous_failure_lock <= 1'b1;
      end else if (manual_reset && both_clear) begin
        alarm_q.dangerous_failure_lock <= 1'b0;
      end
    end
  end

  // warnings follow the input and restart on release
  always_comb begin
    torque_warn_d = relay_stop && (plain_warn || (sensor_mode && !relay_is_alarm));
    sensor_warn_d = card_stop && !sensor_is_alarm;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      torque_warn_q <= 1'b0;
      sensor_warn_q <= 1'b0;
    end else begin
      torque_warn_q <= torque_warn_d;
      sensor_warn_q <= sensor_warn_d;
    end
  end

  // card logic alone never blocks a plain setting
  // In sensor settings card alone is unexpected and stops the drive through the lock
  assign run_enable_d = !tdis && (alarm_q == '0) && !unexpected;

  // Run permission: any live stop or held alarm keeps the drive stopped
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      run_enable_out <= 1'b0;
    end else begin
      run_enable_out <= run_enable_d;
    end
  end

  always_comb begin
    trip_word_d = STATUS_RESET;
    trip_ext_word_d = STATUS_RESET;
    caution_word_d = STATUS_RESET;
    caution_ext_word_d = STATUS_RESET;
    trip_word_d[BIT_TORQUE_OFF] = alarm_q.torque_off_alarm;
    trip_ext_word_d[BIT_TORQUE_OFF] = alarm_q.sensor_torque_off_alarm;
    trip_ext_word_d[BIT_DANGEROUS] = alarm_q.dangerous_failure_lock;
    caution_word_d[BIT_TORQUE_OFF] = torque_warn_q;
    caution_ext_word_d[BIT_TORQUE_OFF] = sensor_warn_q;
  end

  // Words are registered so a reader never sees a half-updated status
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      trip_status_word_out <= STATUS_RESET;
      trip_status_word_ext_out <= STATUS_RESET;
      caution_status_word_out <= STATUS_RESET;
      caution_status_word_ext_out <= STATUS_RESET;
    end else begin
      trip_status_word_out <= trip_word_d;
      trip_status_word_ext_out <= trip_ext_word_d;
      caution_status_word_out <= caution_word_d;
      caution_status_word_ext_out <= caution_ext_word_d;
    end
  end

  // Auto reset is accepted but deliberately has no effect on these alarms
  logic unused_auto;
  assign unused_auto = auto_reset_in;

endmodule : tofm_monitor

//--- test/tofm_monitor_props.sv
// Port-level assertions for the torque-off fault monitor
`timescale 1ns/1ps
module tofm_props
  import tofm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic torque_disable_n_in,
  input wire logic card_logic_output_in,
  input wire logic [3:0] function_select_in,
  input wire logic reset_command_in,
  input wire logic auto_reset_in,
  input wire logic run_enable_out,
  input wire logic [31:0] trip_status_word_out,
  input wire logic [31:0] trip_status_word_ext_out,
  input wire logic [31:0] caution_status_word_out,
  input wire logic [31:0] caution_status_word_ext_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire logic [3:0] f = function_select_in;
  wire logic pin = !torque_disable_n_in;
  wire logic card = card_logic_output_in;
  wire logic lock = trip_status_word_ext_out[31];
  wire logic [2:0] al = {trip_status_word_out[30], trip_status_word_ext_out[30], lock};
  // Five samples cover the two sync stages plus the alarm and output registers
  sequence s_card_alone; (f >= 4'h4 && f <= 4'h9 && card && !pin) [*5]; endsequence
  sequence s_pin_alone; ((f == 4'h4 || f == 4'h5) && pin && !card) [*5]; endsequence
  sequence s_quiet;
    (((f >= 4'h1 && f <= 4'h3) || (f >= 4'h6 && f <= 4'h9 && !card)) && !lock) [*5];
  endsequence
  property p_unused_zero;
    (trip_status_word_out & 32'hBFFF_FFFF) == 32'h0 && (trip_status_word_ext_out & 32'h3FFF_FFFF) == 32'h0
      && ((caution_status_word_out | caution_status_word_ext_out) & 32'hBFFF_FFFF) == 32'h0;
  endproperty
  property p_alarm_hold;
    |($past(al) & ~al) |-> $past(reset_command_in) || $past(reset_command_in, 2);
  endproperty
  property p_stop_on_alarm; |al |-> !run_enable_out; endproperty
  property p_pin_stops; (f != 4'h0 && pin) [*5] |-> !run_enable_out; endproperty
  property p_warn_resume; ((f == 4'h3 || f == 4'h5) && !pin && !card && !(|al)) [*6] |-> run_enable_out;
  endproperty
  property p_lock_card; s_card_alone |-> lock; endproperty
  property p_lock_pin; s_pin_alone |-> lock; endproperty
  property p_no_lock; s_quiet |=> !lock; endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("stray status bit");
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm cleared without reset");
  a_stop_on_alarm: assert property (p_stop_on_alarm) else $error("runs with alarm");
  a_pin_stops: assert property (p_pin_stops) else $error("runs with torque off");
  a_warn_resume: assert property (p_warn_resume) else $error("no restart");
  a_lock_card: assert property (p_lock_card) else $error("card alone not locked");
  a_lock_pin: assert property (p_lock_pin) else $error("pin alone not locked");
  a_no_lock: assert property (p_no_lock) else $error("false lock");
endmodule : tofm_props

bind tofm_monitor tofm_props i_props (.clock_in, .rst_in, .torque_disable_n_in,
  .card_logic_output_in, .function_select_in, .reset_command_in, .auto_reset_in,
  .run_enable_out, .trip_status_word_out, .trip_status_word_ext_out,
  .caution_status_word_out, .caution_status_word_ext_out);

//--- test/tofm_card_model.sv
// Plug-in sensor card model driving the torque-off and logic lines
`timescale 1ns/1ps
module tofm_card_model (
  input wire logic clock_in,
  input wire logic hot_in,
  input wire logic loop_open_in,
  input wire logic fault_in,
  output logic torque_disable_n_out,
  output logic card_logic_output_out
);
  wire logic trip = hot_in || loop_open_in;
  // open loop trips, both lines move on one edge
  // Fault forces logic high alone, only when a test asks for it
  always_ff @(posedge clock_in) begin
    torque_disable_n_out <= !trip;
    card_logic_output_out <= trip || fault_in;
  end
endmodule : tofm_card_model

//--- test/test_torque_off_fault_monitor.sv
// Self-checking bench for the torque-off fault monitor
`timescale 1ns/1ps
module test_torque_off_fault_monitor;
  localparam logic [31:0] B30 = 32'h4000_0000;
  localparam logic [31:0] B31 = 32'h8000_0000;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic [3:0] function_select_in = 4'h0;
  logic reset_command_in = 1'h0;
  logic auto_reset_in = 1'h0;
  logic [3:0] drv = 4'h0;
  logic card_n, card_logic_output_in, run_enable_out, a;
  logic [3:0] f;
  logic [31:0] trip_status_word_out, trip_status_word_ext_out;
  logic [31:0] caution_status_word_out, caution_status_word_ext_out;
  // External relay stop sits in series with the card on the torque-off line
  wire logic torque_disable_n_in = card_n & ~drv[0];
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clock_in = ~clock_in;
  tofm_card_model i_card (.clock_in, .hot_in(drv[3]), .loop_open_in(drv[2]), .fault_in(drv[1]),
    .torque_disable_n_out(card_n), .card_logic_output_out(card_logic_output_in));
  tofm_monitor i_dut (.clock_in, .rst_in, .torque_disable_n_in, .card_logic_output_in,
    .function_select_in, .reset_command_in, .auto_reset_in, .run_enable_out,
    .trip_status_word_out, .trip_status_word_ext_out, .caution_status_word_out,
    .caution_status_word_ext_out);
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic look(logic [31:0] tw, tx, cw, cx, logic run);
    chk("trip", trip_status_word_out, tw);
    chk("trip_ext", trip_status_word_ext_out, tx);
    chk("caution", caution_status_word_out, cw);
    chk("caution_ext", caution_status_word_ext_out, cx);
    chk("run", {31'h0, run_enable_out}, {31'h0, run});
  endtask : look
  // Stimulus nibble: hot, loop open, card fault, relay stop
  task automatic step(logic [3:0] fs, logic [3:0] d);
    @(posedge clock_in);
    {function_select_in, drv} <= {fs, d};
    repeat (8) @(posedge clock_in);
    #1;
  endtask : step
  task automatic clr();
    @(posedge clock_in);
    reset_command_in <= 1'h1;
    @(posedge clock_in);
    reset_command_in <= 1'h0;
    repeat (6) @(posedge clock_in);
    #1;
  endtask : clr
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4000) @(posedge clock_in);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'h0;
    step(4'h1, 4'h1);
    look(B30, Z, Z, Z, 1'h0);
    clr();
    look(B30, Z, Z, Z, 1'h0);
    @(posedge clock_in);
    auto_reset_in <= 1'h1;
    step(4'h1, 4'h0);
    look(B30, Z, Z, Z, 1'h0);
    clr();
    look(Z, Z, Z, Z, 1'h1);
    step(4'h3, 4'h1);
    look(Z, Z, B30, Z, 1'h0);
    step(4'h3, 4'h0);
    look(Z, Z, Z, Z, 1'h1);
    step(4'h2, 4'h2);
    look(Z, Z, Z, Z, 1'h1);
    step(4'h2, 4'h8);
    look(B30, Z, Z, Z, 1'h0);
    step(4'h4, 4'h4);
    look(B30, B30, Z, Z, 1'h0);
    step(4'h4, 4'h0);
    clr();
    look(Z, Z, Z, Z, 1'h1);
    $display("test plain settings done");
    for (int i = 4; i <= 9; i++) begin
      f = 4'(i);
      a = (f == 4'h4 || f == 4'h6 || f == 4'h8);
      step(f, 4'h2);
      look(Z, B31, Z, Z, 1'h0);
      step(f, 4'h0);
      look(Z, B31, Z, Z, 1'h0);
      clr();
      look(Z, Z, Z, Z, 1'h1);
      step(f, 4'h8);
      look(Z, a ? B30 : Z, Z, a ? Z : B30, 1'h0);
      step(f, 4'h0);
      look(Z, a ? B30 : Z, Z, Z, !a);
      clr();
      step(f, 4'h1);
      look((f == 4'h6 || f == 4'h9) ? B30 : Z, f < 4'h6 ? B31 : Z,
        (f == 4'h7 || f == 4'h8) ? B30 : Z, Z, 1'h0);
      step(f, 4'h0);
      clr();
      look(Z, Z, Z, Z, 1'h1);
      $display("test setting %0d done", i);
    end
    tally_and_finish();
  end
endmodule : test_torque_off_fault_monitor
